// >>> rtl/gsso_top.sv
// Operation
// - Sample the sensor continuously with 8 bits and low-pass filter it.
// - Compensate temperature, remove baseline, apply span, linearise via table.
// - Enter warm-up at every reset and stay about thirty seconds.
// - During warm-up sampling and error checks go on, but the reading is zero.
// - After warm-up go normal; stay there without error or gas level.
// - Fall back to normal by itself once the cause clears.
// - Warn when reading reaches a stored percentage of the alarm level.
// - Alarm whenever, outside error and warm-up, the reading is at or above the alarm level.
// - Alarm level is stored configuration, rewritable over the link.
// - Error on sensor loss, temperature out of range or checksum fault.
// - Error drives output code zero in step and proportional modes.
// - Step codes: error 0, warm-up/normal 16, warning 32, alarm 48.
// - Binary output idle polarity and latching selectable.
// - Binary output follows warning, alarm or either.
// - Proportional output rises one code per reading unit.
// - Six-bit code; the offset codes shrink the top reading.
// - Non-error proportional codes carry an offset of seven.
module gsso_top
  import gsso_pkg::*;
#(
  parameter logic [31:0] WARMUP_CYC = 32'(64'(WARMUP_S) * 64'(CLK_HZ)),
  parameter logic [16:0] SAMPLE_CYC = 17'(SAMPLE_US * CLK_PER_US)
) (
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_B_I,
  // Converter pins
  input  wire logic [7:0] GAS_ADC_I,
  input  wire logic [7:0] TEMP_ADC_I,
  // Settings held by the field_config_link logic
  input  wire logic [7:0] ALARM_THR_I,
  input  wire logic [6:0] WARN_PCT_I,
  input  wire logic [7:0] BASELINE_I,
  input  wire logic [7:0] SPAN_I,
  input  wire logic [3:0] TEMP_COEF_I,
  input  wire logic [1:0] OUT_MODE_I,
  input  wire logic [1:0] BIN_SEL_I,
  input  wire logic       BIN_IDLE_HI_I,
  input  wire logic       BIN_LATCH_I,
  input  wire logic       BIN_CLR_I,
  input  wire logic       FW_CRC_FAIL_I,
  // Outputs
  output logic      [5:0] DAC_CODE_O,
  output logic            BIN_O,
  output logic      [2:0] STATE_O,
  output logic      [7:0] READING_O
);

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  gsso_regs_t r;
  gsso_regs_t n;

  // ----------------------------------------
  // Conditioning path
  // ----------------------------------------
  logic               tick;
  logic        [7:0]  filt;
  logic signed [9:0]  tdev;
  logic signed [13:0] corr;
  logic signed [14:0] comp_w;
  logic        [7:0]  comp;
  logic        [7:0]  net;
  logic        [15:0] prod;
  logic        [7:0]  scaled;
  logic        [3:0]  idx;
  logic        [7:0]  lo_v;
  logic        [7:0]  hi_v;
  logic        [11:0] step_w;
  logic        [7:0]  lin;

  // Sample tick from the divider
  assign tick = (r.div == 17'h00000);

  // Filter output: average of about eight samples
  assign filt = r.acc[10:3];

  // Temperature drift correction, signed around the reference
  always_comb begin
    tdev   = $signed({2'b00, r.tmp_s2}) - $signed({2'b00, TEMP_REF});
    corr   = tdev * $signed(TEMP_COEF_I);
    comp_w = $signed({7'h00, filt}) - 15'(corr >>> 3);
    if (comp_w < 0) begin
      comp = 8'h00;
    end else if (comp_w > 15'sd255) begin
      comp = 8'hff;
    end else begin
      comp = comp_w[7:0];
    end
  end

  // Baseline, span, then piecewise-linear table with interpolation
  always_comb begin
    net    = (comp > BASELINE_I) ? comp - BASELINE_I : 8'h00;
    prod   = net * SPAN_I;
    scaled = (prod[15:14] != 2'b00) ? 8'hff : prod[13:6];
    idx    = scaled[7:4];
    lo_v   = LIN_TBL[idx];
    hi_v   = LIN_TBL[5'(idx) + 5'h01];
    step_w = (hi_v - lo_v) * scaled[3:0];
    lin    = lo_v + step_w[11:4];
  end

  // ----------------------------------------
  // Condition detection
  // ----------------------------------------
  logic        warm;
  logic        err;
  logic        alarm_hit;
  logic        warn_hit;
  logic [14:0] warn_prod;
  logic [7:0]  warn_lvl;

  assign warm = (r.warm_cnt != 32'h00000000);

  // Filtered rail values mean a missing or shorted sensor
  assign err = FW_CRC_FAIL_I
             | (r.tmp_s2 < TEMP_MIN) | (r.tmp_s2 > TEMP_MAX)
             | (filt < SENS_LO) | (filt > SENS_HI);

  // Threshold read live so a rewrite takes effect at once
  assign alarm_hit = (r.rdg >= ALARM_THR_I);

  // Divide by a constant; costs area, but only once per block
  always_comb begin
    warn_prod = ALARM_THR_I * WARN_PCT_I;
    warn_lvl  = 8'(warn_prod / 15'(PCT_FULL));
  end
  assign warn_hit = (r.rdg >= warn_lvl);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic cond;
  logic active;

  always_comb begin
    n      = r;
    cond   = 1'b0;
    active = 1'b0;

    // Two-stage synchronisers on the converter pins
    n.adc_s1 = GAS_ADC_I;
    n.adc_s2 = r.adc_s1;
    n.tmp_s1 = TEMP_ADC_I;
    n.tmp_s2 = r.tmp_s1;

    // Sample divider
    n.div = tick ? SAMPLE_CYC - 17'h00001 : r.div - 17'h00001;

    // Warm-up timer counts down once after reset
    if (warm) begin
      n.warm_cnt = r.warm_cnt - 32'h00000001;
    end

    // Filter and reading update on each sample tick
    if (tick) begin
      n.acc = r.acc - 11'(r.acc[10:3]) + 11'(r.adc_s2);
      n.rdg = lin;
    end
    if (warm) begin
      n.rdg = 8'h00;
    end

    // State selection, highest priority first
    if (err) begin
      n.state = ST_ERR;
    end else if (warm) begin
      n.state = ST_WARM;
    end else if (alarm_hit) begin
      n.state = ST_ALRM;
    end else if (warn_hit) begin
      n.state = ST_WARN;
    end else begin
      n.state = ST_NORM;
    end

    // Binary output source
    case (BIN_SEL_I)
      SEL_WARN: cond = (n.state == ST_WARN);
      SEL_ALRM: cond = (n.state == ST_ALRM);
      SEL_BOTH: cond = (n.state == ST_WARN) | (n.state == ST_ALRM);
      default:  cond = 1'b0;
    endcase

    // Latch: a new event beats a clear in the same cycle
    n.latch = BIN_LATCH_I & ((r.latch & ~BIN_CLR_I) | cond);
    active  = BIN_LATCH_I ? n.latch : cond;
    n.bin   = active ^ BIN_IDLE_HI_I;

    // Output code encoder
    case (OUT_MODE_I)
      MODE_STEP: begin
        case (n.state)
          ST_ERR:  n.dac = CODE_ERR;
          ST_WARN: n.dac = CODE_WARN;
          ST_ALRM: n.dac = CODE_ALRM;
          default: n.dac = CODE_NORM;
        endcase
      end
      MODE_PROP: begin
        if (n.state == ST_ERR) begin
          n.dac = CODE_ERR;
        end else if (n.rdg > PROP_MAX) begin
          n.dac = PROP_OFS + PROP_MAX[5:0];
        end else begin
          n.dac = PROP_OFS + n.rdg[5:0];
        end
      end
      default: n.dac = CODE_ERR;
    endcase
  end

  // ----------------------------------------
  // Register stage
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      r.adc_s1   <= ADC_RST;
      r.adc_s2   <= ADC_RST;
      r.tmp_s1   <= TEMP_REF;
      r.tmp_s2   <= TEMP_REF;
      r.acc      <= ACC_RST;
      r.div      <= 17'h00000;
      r.warm_cnt <= WARMUP_CYC;
      r.rdg      <= 8'h00;
      r.state    <= ST_WARM;
      r.latch    <= 1'b0;
      r.dac      <= CODE_ERR;
      r.bin      <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign DAC_CODE_O = r.dac;
  assign BIN_O      = r.bin;
  assign STATE_O    = r.state;
  assign READING_O  = r.rdg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_warmup_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (warm && !err) |=> (STATE_O == ST_WARM))
    else $error("left warm-up early");

  a_warm_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (STATE_O == ST_WARM) |-> (READING_O == 8'h00))
    else $error("reading not zero in warm-up");

  a_alarm_enter: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!err && !warm && alarm_hit) |=> (STATE_O == ST_ALRM))
    else $error("alarm level missed");

  a_err_enter: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    err |=> (STATE_O == ST_ERR) && (DAC_CODE_O == CODE_ERR))
    else $error("error not entered");

  a_warn_enter: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!err && !warm && !alarm_hit && warn_hit) |=> (STATE_O == ST_WARN))
    else $error("warning level missed");

  a_norm_return: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ((STATE_O != ST_NORM) && !err && !warm && !warn_hit && !alarm_hit)
      |=> (STATE_O == ST_NORM))
    else $error("no return to normal");

  a_step_code: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ($past(OUT_MODE_I) == MODE_STEP && STATE_O == ST_ALRM)
      |-> (DAC_CODE_O == CODE_ALRM))
    else $error("wrong alarm step code");

  a_prop_offset: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ($past(OUT_MODE_I) == MODE_PROP && STATE_O != ST_ERR
      && READING_O <= PROP_MAX)
      |-> (DAC_CODE_O == PROP_OFS + READING_O[5:0]))
    else $error("proportional code wrong");

  a_bin_auto: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ($past(BIN_LATCH_I) == 1'b0 && $past(BIN_SEL_I) == SEL_ALRM)
      |-> (BIN_O == ((STATE_O == ST_ALRM) ^ $past(BIN_IDLE_HI_I))))
    else $error("binary output mismatch");

endmodule : gsso_top

// >>> rtl/gsso_pkg.sv
package gsso_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned WARMUP_S   = 30;
  localparam int unsigned SAMPLE_US  = 1000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;

  // ----------------------------------------
  // Output codes and modes
  // ----------------------------------------
  localparam logic [1:0] MODE_BIN  = 2'h0;
  localparam logic [1:0] MODE_STEP = 2'h1;
  localparam logic [1:0] MODE_PROP = 2'h2;
  localparam logic [1:0] SEL_WARN  = 2'h0;
  localparam logic [1:0] SEL_ALRM  = 2'h1;
  localparam logic [1:0] SEL_BOTH  = 2'h2;
  localparam logic [5:0] CODE_ERR  = 6'h00;
  localparam logic [5:0] CODE_NORM = 6'h10;
  localparam logic [5:0] CODE_WARN = 6'h20;
  localparam logic [5:0] CODE_ALRM = 6'h30;
  localparam logic [5:0] PROP_OFS  = 6'h07;
  localparam logic [7:0] PROP_MAX  = 8'h38;

  // ----------------------------------------
  // Conditioning constants and reset values
  // ----------------------------------------
  localparam logic [10:0] ACC_RST  = 11'h400;
  localparam logic [7:0]  ADC_RST  = 8'h80;
  localparam logic [7:0]  TEMP_REF = 8'h80;
  localparam logic [7:0]  TEMP_MIN = 8'h10;
  localparam logic [7:0]  TEMP_MAX = 8'hf0;
  localparam logic [7:0]  SENS_LO  = 8'h02;
  localparam logic [7:0]  SENS_HI  = 8'hfd;
  localparam logic [6:0]  PCT_FULL = 7'h64;
  localparam logic [7:0] LIN_TBL [17] = '{
    8'h00, 8'h04, 8'h09, 8'h0e, 8'h14, 8'h1b, 8'h23, 8'h2c, 8'h36,
    8'h42, 8'h50, 8'h60, 8'h72, 8'h87, 8'ha0, 8'hbe, 8'hff};

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_WARM = 3'b000,
    ST_NORM = 3'b001,
    ST_WARN = 3'b010,
    ST_ALRM = 3'b011,
    ST_ERR  = 3'b100
  } gsso_state_t;

  typedef struct packed {
    logic [7:0]  adc_s1;
    logic [7:0]  adc_s2;
    logic [7:0]  tmp_s1;
    logic [7:0]  tmp_s2;
    logic [10:0] acc;
    logic [16:0] div;
    logic [31:0] warm_cnt;
    logic [7:0]  rdg;
    gsso_state_t state;
    logic        latch;
    logic [5:0]  dac;
    logic        bin;
  } gsso_regs_t;

endpackage : gsso_pkg

// >>> verif/gsso_reader_model.sv
module gsso_reader_model (
  // Line from the device
  input  wire logic [5:0] code_i,
  input  wire logic [7:0] thr_i,
  // Decoded view
  output logic      [5:0] net_o,
  output logic            fault_o,
  output logic            alarm_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Reader strips the offset; a code below it means error or broken wiring
  always_comb begin
    fault_o = (code_i < 6'h07);
    net_o   = fault_o ? 6'h00 : code_i - 6'h07;
    alarm_o = !fault_o && ({2'h0, net_o} >= thr_i);
  end
endmodule : gsso_reader_model

// >>> verif/gsso_top_tb_top.sv
module gsso_top_tb_top;
  import gsso_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CMP(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  typedef struct {int f; logic [7:0] e;} gsso_note_t;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] gas = 8'h60;
  logic [7:0] temp = 8'h80;
  logic [7:0] thr = 8'h00;
  logic [6:0] pct = 7'h32;
  logic [1:0] mode = MODE_STEP;
  logic [1:0] sel = SEL_ALRM;
  logic       idle = 1'b0;
  logic       latch = 1'b0;
  logic       clr = 1'b0;
  logic       crc = 1'b0;
  logic [5:0] dac_o;
  logic       bin_o;
  logic [2:0] st_o;
  logic [7:0] rdg_o;
  logic [5:0] rd_net;
  logic       rd_fault;
  logic       rd_alarm;
  int         failures = 0;
  int         num_checks = 0;
  logic [31:0] seed = 32'h3400;
  gsso_note_t notes[$];
  event       chk_ev;
  string      fname[7] = '{"state", "dac", "bin", "reading", "rd_alarm", "rd_fault", "rd_net"};

  // Short counts keep the run brief; expectations use these values
  gsso_top #(.WARMUP_CYC(32'd200), .SAMPLE_CYC(17'd4)) u_gsso_top (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .GAS_ADC_I(gas), .TEMP_ADC_I(temp),
    .ALARM_THR_I(thr), .WARN_PCT_I(pct), .BASELINE_I(8'h20), .SPAN_I(8'h40),
    .TEMP_COEF_I(4'h0), .OUT_MODE_I(mode), .BIN_SEL_I(sel), .BIN_IDLE_HI_I(idle),
    .BIN_LATCH_I(latch), .BIN_CLR_I(clr), .FW_CRC_FAIL_I(crc),
    .DAC_CODE_O(dac_o), .BIN_O(bin_o), .STATE_O(st_o), .READING_O(rdg_o));
  gsso_reader_model u_gsso_reader_model (.code_i(dac_o), .thr_i(thr), .net_o(rd_net),
    .fault_o(rd_fault), .alarm_o(rd_alarm));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [7:0] get(int f);
    case (f)
      0: return {5'h00, st_o};
      1: return {2'h0, dac_o};
      2: return {7'h00, bin_o};
      3: return rdg_o;
      4: return {7'h00, rd_alarm};
      5: return {7'h00, rd_fault};
      default: return {2'h0, rd_net};
    endcase
  endfunction : get

  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Caller yields until the checker has taken the note, so a later input
  // change in the same time step cannot race the comparison
  task automatic note(int f, logic [7:0] e);
    notes.push_back('{f, e});
    -> chk_ev;
    for (int k = 0; k < 4 && notes.size() > 0; k++) #0;
    if (notes.size() > 0) begin
      failures++;
      finish_test();
    end
  endtask : note

  task automatic finish_test();
    #1;
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Bounded wait for an output to reach a value; the filter settles slowly
  task automatic wait_for(int f, logic [7:0] e);
    int i;
    for (i = 0; i < 3000 && get(f) !== e; i++) tick(1);
    if (i == 3000) begin
      failures++;
      $display("[ERR] wait %s exp=%0h got=%0h", fname[f], e, get(f));
      finish_test();
    end
  endtask : wait_for

  // Reading settles at 20 units (gas 0x60, baseline 0x20)
  task automatic cfg_case(logic [7:0] t, logic [6:0] p, logic [1:0] m, logic [1:0] s,
                          logic ih);
    int wl;
    logic [2:0] st;
    logic act;
    logic [5:0] dac;
    thr = t; pct = p; mode = m; sel = s; idle = ih;
    tick(3);
    wl = (int'(t) * int'(p)) / 100;
    st = (8'd20 >= t) ? ST_ALRM : (20 >= wl) ? ST_WARN : ST_NORM;
    act = (s == SEL_WARN) ? st == ST_WARN : (s == SEL_ALRM) ? st == ST_ALRM :
          (s == SEL_BOTH) ? st != ST_NORM : 1'b0;
    // Step codes put the state number in the top two bits
    dac = (m == MODE_PROP) ? 6'h1b : (m == MODE_STEP) ? {st[1:0], 4'h0} : 6'h00;
    note(0, {5'h00, st});
    note(1, {2'h0, dac});
    note(2, {7'h00, act ^ ih});
    if (m == MODE_PROP) note(4, {7'h00, t <= 8'd20});
  endtask : cfg_case

  // ----------------------------------------
  // Checker and main sequence
  // ----------------------------------------
  initial begin : mon
    gsso_note_t n;
    forever begin
      @(chk_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        `CMP(fname[n.f], n.e, get(n.f))
      end
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    tick(50);
    note(0, 8'h00);
    note(3, 8'h00);
    note(1, 8'h10);
    crc = 1'b1;
    tick(3);
    note(0, 8'h04);
    note(1, 8'h00);
    crc = 1'b0;
    tick(142);
    note(0, 8'h00);
    thr = 8'hc8;
    tick(15);
    note(0, 8'h01);
    wait_for(3, 8'h14);
    note(3, 8'h14);
    cfg_case(8'd20, 7'd50, MODE_STEP, SEL_ALRM, 1'b0);
    cfg_case(8'd21, 7'd96, MODE_STEP, SEL_WARN, 1'b1);
    cfg_case(8'd200, 7'd50, MODE_PROP, SEL_BOTH, 1'b0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      cfg_case(seed[7:0], 7'(seed[14:8] % 101), 2'(i % 3), seed[18:17], seed[16]);
    end
    // Latched binary output survives the cause until cleared
    // Latch mode must be on while the alarm stands, or nothing is captured
    latch = 1'b1;
    cfg_case(8'd10, 7'd50, MODE_BIN, SEL_ALRM, 1'b0);
    thr = 8'd200;
    tick(3);
    note(0, 8'h01);
    note(1, 8'h00);
    note(3, 8'h14);
    note(2, 8'h01);
    clr = 1'b1;
    tick(3);
    clr = 1'b0;
    tick(2);
    note(2, 8'h00);
    latch = 1'b0;
    mode = MODE_PROP;
    temp = 8'h05;
    tick(5);
    note(0, 8'h04);
    note(1, 8'h00);
    note(5, 8'h01);
    temp = 8'h80;
    tick(5);
    note(0, 8'h01);
    note(1, 8'h1b);
    note(6, 8'h14);
    gas = 8'h00;
    wait_for(0, 8'h04);
    note(1, 8'h00);
    gas = 8'hfc;
    wait_for(3, 8'h99);
    tick(3);
    note(1, 8'h3f);
    finish_test();
  end
endmodule : gsso_top_tb_top
